// File: bench/function_mux_asserts.sv
// Bus and route checks for the pin function select block
`timescale 1ns/10ps
module function_mux_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_read_data,
  input wire logic [12:0] general_io_route_enable,
  input wire logic second_uart_receive_route_enable,
  input wire logic pin_interrupt_group0_line3_route_enable,
  input wire logic [1:0] voltage_dac_out_route_enable,
  input wire logic [12:0] pin_analog_free
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_reset_clear: assert property (
    $rose(rst_b) |-> general_io_route_enable == 13'h0000)
    else $error("route set after reset");
  a_read_idle: assert property (
    !$past(reg_read) |-> reg_read_data == 8'h00)
    else $error("read data outside read slot");
  a_read_unmapped: assert property (
    reg_read && (reg_addr < 16'ha073 || reg_addr > 16'ha07f) |=>
    reg_read_data == 8'h00)
    else $error("unmapped read not zero");
  a_gpio_route: assert property (
    reg_write && reg_addr == 16'ha073 |-> ##2
    general_io_route_enable[0] == $past(reg_write_data[0], 2))
    else $error("gpio route wrong");
  a_gpio_hold: assert property (
    !$past(reg_write, 2) |-> $stable(general_io_route_enable))
    else $error("gpio route moved without write");
  a_uart_irq_pair: assert property (
    second_uart_receive_route_enable ==
    pin_interrupt_group0_line3_route_enable)
    else $error("receive and interrupt routes differ");
  a_dac_route: assert property (
    reg_write && reg_addr == 16'ha07a |-> ##2
    voltage_dac_out_route_enable[1] == $past(reg_write_data[7], 2))
    else $error("dac route wrong");
  a_free_excl: assert property (
    pin_analog_free[0] |-> !general_io_route_enable[0] &&
    !second_uart_receive_route_enable && !voltage_dac_out_route_enable[0])
    else $error("free pin still routed");
endmodule : function_mux_checker
bind port2_port3_function_mux function_mux_checker function_mux_checker_i (
  .sys_clk, .rst_b, .reg_addr, .reg_write_data, .reg_write, .reg_read,
  .reg_read_data, .general_io_route_enable, .second_uart_receive_route_enable,
  .pin_interrupt_group0_line3_route_enable, .voltage_dac_out_route_enable,
  .pin_analog_free);

// File: bench/pin23_owner_model.sv
// Peripheral side of pin P2.3: counts the functions holding the pin
`timescale 1ns/10ps
module pin23_owner_model (
  input wire logic gpio_route,
  input wire logic uart_route,
  input wire logic dac_route,
  output logic [1:0] owner_count
);
  // Receive and interrupt share one select bit, so counted once
  assign owner_count = 2'(gpio_route) + 2'(uart_route) +
    2'(dac_route);
endmodule : pin23_owner_model

// File: bench/tb_port2_port3_function_mux.sv
// Self-checking bench for the pin function select block
`timescale 1ns/10ps
module tb_port2_port3_function_mux;
  logic sys_clk, rst_b, reg_write, reg_read;
  logic [15:0] reg_addr;
  logic [7:0] reg_write_data, reg_read_data;
  logic [12:0] gpio, free;
  logic [11:0] per;
  logic [1:0] dac, owners;
  int n_mismatch = 0;
  int n_tests = 0;
  port2_port3_function_mux port2_port3_function_mux_i (
    .sys_clk, .rst_b, .reg_addr, .reg_write_data, .reg_write, .reg_read,
    .reg_read_data, .general_io_route_enable(gpio),
    .second_uart_receive_route_enable(per[11]),
    .pin_interrupt_group0_line3_route_enable(per[10]),
    .voltage_dac_out_route_enable(dac), .timer2_trigger_route_enable(per[9]),
    .timer2_count_input_route_enable(per[8]),
    .counter_array_ch2_route_enable(per[7]),
    .counter_array_ch3_route_enable(per[6]),
    .counter_array_ch4_route_enable(per[5]),
    .counter_array_ch5_route_enable(per[4]),
    .spi_chip_select_route_enable(per[3]),
    .spi_controller_out_route_enable(per[2]),
    .spi_controller_in_route_enable(per[1]),
    .spi_serial_clock_route_enable(per[0]), .pin_analog_free(free));
  pin23_owner_model pin23_owner_model_i (.gpio_route(gpio[0]),
    .uart_route(per[11]), .dac_route(dac[0]), .owner_count(owners));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_write, reg_addr, reg_write_data} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    {reg_read, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(16'(reg_read_data), 16'(exp));
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle
  // Writable bits differ per pin: DAC pins, GPIO-only pins, the rest
  function automatic logic [7:0] mask_of(input int i);
    if (i == 0 || i == 7) return pin_function_pkg::MASK_WITH_DAC;
    if (i == 3 || i == 4) return pin_function_pkg::MASK_GPIO_ONLY;
    return pin_function_pkg::MASK_PERIPHERAL;
  endfunction : mask_of
  task automatic reset_values;
    for (int i = 0; i < 13; i++) rd(16'ha073 + 16'(i), 8'h00);
    chk(16'(free), 16'h1fff);
  endtask : reset_values
  task automatic all_bits_set;
    for (int i = 0; i < 13; i++) wr(16'ha073 + 16'(i), 8'hff);
    for (int i = 0; i < 13; i++)
      rd(16'ha073 + 16'(i), mask_of(i));
    chk(16'(gpio), 16'h1fff);
    chk(16'(per), 16'h0fff);
    chk(16'({dac, owners}), 16'h000f);
    for (int i = 0; i < 13; i++) wr(16'ha073 + 16'(i), 8'h00);
    settle();
    chk({per, dac, owners}, 16'h0000);
    chk(16'(free), 16'h1fff);
  endtask : all_bits_set
  // Peripheral route expected from each pin's bit 1, one pin at a time
  function automatic logic [11:0] per_of(input int i);
    case (i)
      0: return 12'hc00;
      1: return 12'h200;
      2: return 12'h100;
      5: return 12'h080;
      6: return 12'h040;
      7: return 12'h020;
      8: return 12'h010;
      9: return 12'h008;
      10: return 12'h004;
      11: return 12'h002;
      12: return 12'h001;
      default: return 12'h000;
    endcase
  endfunction : per_of
  // One pin at a time, so a swapped route cannot hide behind all ones
  task automatic single_routes;
    for (int i = 0; i < 13; i++) begin
      wr(16'ha073 + 16'(i), 8'h02);
      settle();
      chk(16'(per), 16'(per_of(i)));
      wr(16'ha073 + 16'(i), 8'h01);
      settle();
      chk(16'(gpio), 16'(13'h0001 << i));
      wr(16'ha073 + 16'(i), 8'h00);
    end
    wr(16'ha07a, 8'h80);
    settle();
    chk(16'({dac, per}), 16'h2000);
    wr(16'ha07a, 8'h00);
    settle();
    chk(16'(dac), 16'h0000);
  endtask : single_routes
  task automatic unmapped_access;
    wr(16'ha080, 8'hff);
    wr(16'ha072, 8'h01);
    rd(16'ha080, 8'h00);
    rd(16'ha073, 8'h00);
    wr(16'ha073, 8'h01);
    settle();
    chk(16'({free[0], owners}), 16'h0001);
  endtask : unmapped_access
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, reg_write, reg_read, reg_addr, reg_write_data} = '0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    reset_values();
    all_bits_set();
    single_routes();
    unmapped_access();
    print_verdict();
  end
  // Hang guard: far beyond the few hundred cycles of the run
  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_port2_port3_function_mux

// File: rtl/function_select_reg.sv
// One byte-wide pin function select register with writable-bit mask
`timescale 1ns/10ps
module function_select_reg #(
  parameter logic [7:0] WRITE_MASK = 8'h01
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic write_hit,
  input wire logic [7:0] write_data,
  output logic [7:0] value
);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      value <= pin_function_pkg::FUNCTION_SELECT_RESET; // RL2
    end else if (write_hit) begin
      // Unused bits never store, so they read back as zero
      value <= write_data & WRITE_MASK; // RL13
    end
  end
endmodule : function_select_reg

// File: rtl/pin_function_pkg.sv
// Register map and field layout of the port 2/3 pin function selectors
package pin_function_pkg;
  localparam int ADDR_WIDTH = 16;
  localparam int PIN_COUNT = 13;
  localparam logic [15:0] PORT2_PIN3_FUNCTION_SELECT = 16'ha073;
  localparam logic [15:0] PORT2_PIN4_FUNCTION_SELECT = 16'ha074;
  localparam logic [15:0] PORT2_PIN5_FUNCTION_SELECT = 16'ha075;
  localparam logic [15:0] PORT2_PIN6_FUNCTION_SELECT = 16'ha076;
  localparam logic [15:0] PORT2_PIN7_FUNCTION_SELECT = 16'ha077;
  localparam logic [15:0] PORT3_PIN0_FUNCTION_SELECT = 16'ha078;
  localparam logic [15:0] PORT3_PIN1_FUNCTION_SELECT = 16'ha079;
  localparam logic [15:0] PORT3_PIN2_FUNCTION_SELECT = 16'ha07a;
  localparam logic [15:0] PORT3_PIN3_FUNCTION_SELECT = 16'ha07b;
  localparam logic [15:0] PORT3_PIN4_FUNCTION_SELECT = 16'ha07c;
  localparam logic [15:0] PORT3_PIN5_FUNCTION_SELECT = 16'ha07d;
  localparam logic [15:0] PORT3_PIN6_FUNCTION_SELECT = 16'ha07e;
  localparam logic [15:0] PORT3_PIN7_FUNCTION_SELECT = 16'ha07f;
  localparam logic [7:0] FUNCTION_SELECT_RESET = 8'h00;
  localparam int GENERAL_IO_ROUTE_ENABLE_BIT = 0;
  localparam int PERIPHERAL_ROUTE_ENABLE_BIT = 1;
  localparam int VOLTAGE_DAC_OUT_ROUTE_ENABLE_BIT = 7;
  // Writable bits: bit 0 everywhere, bit 1 except on P2.6/P2.7, bit 7 on the two DAC pins
  localparam logic [7:0] MASK_GPIO_ONLY = 8'h01;
  localparam logic [7:0] MASK_PERIPHERAL = 8'h03;
  localparam logic [7:0] MASK_WITH_DAC = 8'h83;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : pin_function_pkg

// File: rtl/port2_port3_function_mux.sv
// Pin function selection for port 2 pins 3-7 and port 3 pins 0-7
// Contract
// [RL1] Software sets at most one select bit
// [RL2] Every select register resets to zero
// [RL3] Thirteen byte registers decoded, read equals write
// [RL4] Bit 0 routes pin to GPIO
// [RL5] P2.3 bit 1: UART2 receive and interrupt
// [RL6] Bit 7 on P2.3/P3.2 drives DAC out
// [RL7] P2.4 bit 1: timer 2 trigger
// [RL8] P2.5 bit 1: timer 2 count input
// [RL9] Comparator inputs need zero select, analog pad
// [RL10] P3.0-P3.3 bit 1: counter array channels
// [RL11] P3.4 bit 1: slave chip select input
// [RL12] P3.5-P3.7 bit 1: SPI MOSI, MISO, clock
// [RL13] Unused bits read zero, writes ignored
// [RL14] All zero: pin left free for analog; pin_analog_free resets to zero while rst_b is low
`timescale 1ns/10ps
module port2_port3_function_mux (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_read_data,
  output logic [12:0] general_io_route_enable,
  output logic second_uart_receive_route_enable,
  output logic pin_interrupt_group0_line3_route_enable,
  output logic [1:0] voltage_dac_out_route_enable,
  output logic timer2_trigger_route_enable,
  output logic timer2_count_input_route_enable,
  output logic counter_array_ch2_route_enable,
  output logic counter_array_ch3_route_enable,
  output logic counter_array_ch4_route_enable,
  output logic counter_array_ch5_route_enable,
  output logic spi_chip_select_route_enable,
  output logic spi_controller_out_route_enable,
  output logic spi_controller_in_route_enable,
  output logic spi_serial_clock_route_enable,
  output logic [12:0] pin_analog_free
);
  // Index 0 is port 2 pin 3, index 12 is port 3 pin 7
  logic [7:0] select [pin_function_pkg::PIN_COUNT];
  logic [7:0] next_select [pin_function_pkg::PIN_COUNT];
  logic [12:0] write_hit;
  logic [3:0] pin_index;
  logic addr_hit;
  logic [15:0] addr_offset;

  assign addr_offset =
    16'(reg_addr - pin_function_pkg::PORT2_PIN3_FUNCTION_SELECT);
  assign addr_hit =
    (reg_addr >= pin_function_pkg::PORT2_PIN3_FUNCTION_SELECT) &&
    (reg_addr <= pin_function_pkg::PORT3_PIN7_FUNCTION_SELECT); // RL3
  assign pin_index = addr_offset[3:0];

  genvar g;
  generate
    for (g = 0; g < pin_function_pkg::PIN_COUNT; g++) begin : g_pin
      // P2.6 and P2.7 have only the GPIO bit; P2.3 and P3.2 add the DAC
      localparam logic [7:0] MASK =
        (g == 3 || g == 4) ? pin_function_pkg::MASK_GPIO_ONLY :
        (g == 0 || g == 7) ? pin_function_pkg::MASK_WITH_DAC :
        pin_function_pkg::MASK_PERIPHERAL;
      assign write_hit[g] = reg_write && addr_hit &&
        (pin_index == 4'(g)); // RL3
      function_select_reg #(
        .WRITE_MASK(MASK)
      ) u_reg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .write_hit(write_hit[g]),
        .write_data(reg_write_data),
        .value(next_select[g])
      );
      assign select[g] = next_select[g];
    end
  endgenerate

  // Read data lasts one cycle per cycle of reg_read, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_read_data <= pin_function_pkg::READ_UNMAPPED;
    end else if (reg_read && addr_hit) begin
      reg_read_data <= select[pin_index]; // RL3
    end else begin
      reg_read_data <= pin_function_pkg::READ_UNMAPPED;
    end
  end

  // Routes are registered so outputs come from flip-flops; they trail
  // the register write by one cycle. Software owns exclusivity, so
  // conflicting bits are passed through rather than arbitrated. RL1
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      general_io_route_enable <= 13'h0000;
      pin_analog_free <= 13'h0000;
    end else begin
      for (int i = 0; i < pin_function_pkg::PIN_COUNT; i++) begin
        general_io_route_enable[i] <=
          next_select[i][pin_function_pkg::GENERAL_IO_ROUTE_ENABLE_BIT]; // RL4
        // Comparator pins rely on this plus the pad analog enable RL9
        pin_analog_free[i] <= (next_select[i] == 8'h00); // RL14
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_uart_receive_route_enable <= 1'b0;
      pin_interrupt_group0_line3_route_enable <= 1'b0;
      voltage_dac_out_route_enable <= 2'h0;
      timer2_trigger_route_enable <= 1'b0;
      timer2_count_input_route_enable <= 1'b0;
    end else begin
      second_uart_receive_route_enable <=
        next_select[0][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL5
      pin_interrupt_group0_line3_route_enable <=
        next_select[0][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL5
      // Pad analog enable must also be set by software
      voltage_dac_out_route_enable[0] <= // RL6
        next_select[0][pin_function_pkg::VOLTAGE_DAC_OUT_ROUTE_ENABLE_BIT];
      voltage_dac_out_route_enable[1] <= // RL6
        next_select[7][pin_function_pkg::VOLTAGE_DAC_OUT_ROUTE_ENABLE_BIT];
      timer2_trigger_route_enable <=
        next_select[1][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL7
      timer2_count_input_route_enable <=
        next_select[2][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL8
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_array_ch2_route_enable <= 1'b0;
      counter_array_ch3_route_enable <= 1'b0;
      counter_array_ch4_route_enable <= 1'b0;
      counter_array_ch5_route_enable <= 1'b0;
      spi_chip_select_route_enable <= 1'b0;
      spi_controller_out_route_enable <= 1'b0;
      spi_controller_in_route_enable <= 1'b0;
      spi_serial_clock_route_enable <= 1'b0;
    end else begin
      counter_array_ch2_route_enable <=
        next_select[5][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL10
      counter_array_ch3_route_enable <=
        next_select[6][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL10
      counter_array_ch4_route_enable <=
        next_select[7][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL10
      counter_array_ch5_route_enable <=
        next_select[8][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL10
      // Only meaningful while the SPI controller is a slave
      spi_chip_select_route_enable <=
        next_select[9][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL11
      spi_controller_out_route_enable <=
        next_select[10][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL12
      spi_controller_in_route_enable <=
        next_select[11][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL12
      spi_serial_clock_route_enable <=
        next_select[12][pin_function_pkg::PERIPHERAL_ROUTE_ENABLE_BIT]; // RL12
    end
  end
endmodule : port2_port3_function_mux
